// [hdl/srss_top.v]
`timescale 1ns/1ps
`include "srss_defs.vh"
// Reset request, suspend notice, clock-run and wake sideband logic
module srss_top #(
  parameter [`SRSS_CNT_W-1:0] DEBOUNCE_CYC = `SRSS_DEBOUNCE_CYC,
  parameter [`SRSS_CNT_W-1:0] BUSY_WAIT_CYC =
    `SRSS_BUSY_WAIT_CYC
) (
  // Clock and reset
  input wire clk_i,
  input wire resetn_i,
  // Reset request pin and SMBus state
  input wire system_reset_request_n_i,
  input wire smbus_busy_i,
  // Regulator alert pin
  input wire regulator_alert_n_i,
  // Sleep state and mode controls
  input wire sleep_state_i,
  input wire deep_sleep_state_i,
  input wire espi_mode_i,
  input wire suspend_soon_i,
  input wire sideband_reset_req_i,
  input wire clock_stop_req_i,
  input wire deep_sleep_config_pd_i,
  // Open-drain wake line
  input wire pcie_wake_n_i,
  output reg pcie_wake_n_o,
  output reg pcie_wake_n_oe_o,
  // Open-drain clock-run line
  input wire clock_run_request_n_i,
  output reg clock_run_request_n_o,
  output reg clock_run_request_n_oe_o,
  // Outputs
  output reg internal_reset_req_o,
  output reg throttle_o,
  output reg wake_event_o,
  output reg lpc_clock_enable_o,
  output reg suspend_notice_n_o,
  output reg pulldown_en_o
);
  // Sequencer state codes
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_WAIT = 2'h1;
  localparam [1:0] ST_RESET = 2'h2;

  wire [`SRSS_PIN_W-1:0] pin_s;
  wire [`SRSS_PIN_W-1:0] pin_act_s;
  wire rst_req_s;
  wire alert_s;
  wire wake_s;
  wire clock_run_request_n_s;
  wire wait_done_s;
  wire quiet_done_s;
  reg [`SRSS_CNT_W-1:0] deb_cnt_r;
  reg rst_deb_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [`SRSS_CNT_W-1:0] wait_cnt_r;
  reg [`SRSS_CLOCK_RUN_REQUEST_N_W-1:0] quiet_r;
  genvar gi;

  // All pins are asynchronous; idle-high reset avoids false requests
  srss_sync #(
    .W(`SRSS_PIN_W),
    .INIT(`SRSS_PIN_IDLE)
  ) u_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .d_i({system_reset_request_n_i, regulator_alert_n_i,
          pcie_wake_n_i, clock_run_request_n_i}),
    .q_o(pin_s)
  );

  // Every pin is active low; turn each into an active-high level
  generate
    for (gi = 0; gi < `SRSS_PIN_W; gi = gi + 1) begin : g_pin
      assign pin_act_s[gi] = ~pin_s[gi];
    end
  endgenerate

  // Named views of the synchronised pins
  assign rst_req_s = pin_act_s[`SRSS_PIN_RST];
  assign alert_s = pin_act_s[`SRSS_PIN_ALERT];
  assign wake_s = pin_act_s[`SRSS_PIN_WAKE];
  assign clock_run_request_n_s = pin_act_s[`SRSS_PIN_CLOCK_RUN_REQUEST_N];

  // Debounce: level must differ for the whole interval to flip.
  // Chatter restarts the count; a zero interval is not supported.
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      deb_cnt_r <= {`SRSS_CNT_W{1'h0}};
      rst_deb_r <= 1'h0;
    end else if (rst_req_s == rst_deb_r) begin
      deb_cnt_r <= {`SRSS_CNT_W{1'h0}};
    end else if (deb_cnt_r >= DEBOUNCE_CYC - 1'h1) begin
      deb_cnt_r <= {`SRSS_CNT_W{1'h0}};
      rst_deb_r <= rst_req_s;
    end else begin
      deb_cnt_r <= deb_cnt_r + 1'h1;
    end
  end

  // Bus wait limit reached
  assign wait_done_s = (wait_cnt_r >= BUSY_WAIT_CYC - 1'h1);

  // Reset sequencer next state
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (rst_deb_r && !smbus_busy_i) begin
          state_nxt = ST_RESET;
        end else if (rst_deb_r) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Timeout forces reset even with bus still busy
        if (!smbus_busy_i || wait_done_s) begin
          state_nxt = ST_RESET;
        end
      end
      ST_RESET: begin
        // Held while the debounced request stays asserted
        if (!rst_deb_r) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Sequencer state register
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Wait counter, cleared outside the wait so each request gets the bound
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      wait_cnt_r <= {`SRSS_CNT_W{1'h0}};
    end else if (state_r == ST_WAIT) begin
      wait_cnt_r <= wait_cnt_r + 1'h1;
    end else begin
      wait_cnt_r <= {`SRSS_CNT_W{1'h0}};
    end
  end

  // Reset output registered from the next state to save a cycle
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      internal_reset_req_o <= 1'h0;
    end else begin
      internal_reset_req_o <= (state_nxt == ST_RESET);
    end
  end

  // Stop request has seen a quiet line long enough
  assign quiet_done_s = (quiet_r >= `SRSS_CLOCK_RUN_REQUEST_N_QUIET - 4'h1);

  // Clock-run: any peripheral holding the line low keeps clocks on
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      quiet_r <= {`SRSS_CLOCK_RUN_REQUEST_N_W{1'h0}};
      lpc_clock_enable_o <= 1'h1;
    end else if (clock_run_request_n_s || !clock_stop_req_i) begin
      quiet_r <= {`SRSS_CLOCK_RUN_REQUEST_N_W{1'h0}};
      lpc_clock_enable_o <= 1'h1;
    end else if (quiet_done_s) begin
      lpc_clock_enable_o <= 1'h0;
    end else begin
      quiet_r <= quiet_r + 1'h1;
    end
  end

  // Device pulls the line low for a cycle when a stop is lifted, so
  // peripherals see the restart; open drain, so data is always low
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      clock_run_request_n_o <= 1'h0;
      clock_run_request_n_oe_o <= 1'h0;
    end else begin
      clock_run_request_n_o <= 1'h0;
      clock_run_request_n_oe_o <= !lpc_clock_enable_o &&
        !clock_stop_req_i;
    end
  end

  // Wake line is input-only in sleep; never driven by this block
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      pcie_wake_n_o <= 1'h0;
      pcie_wake_n_oe_o <= 1'h0;
      wake_event_o <= 1'h0;
    end else begin
      pcie_wake_n_o <= 1'h0;
      pcie_wake_n_oe_o <= 1'h0;
      wake_event_o <= sleep_state_i && wake_s;
    end
  end

  // Regulator alert passed on as a throttle level
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      throttle_o <= 1'h0;
    end else begin
      throttle_o <= alert_s;
    end
  end

  // Pin function follows host interface mode; low through reset
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      suspend_notice_n_o <= 1'h0;
    end else if (espi_mode_i) begin
      suspend_notice_n_o <= !sideband_reset_req_i;
    end else begin
      suspend_notice_n_o <= !suspend_soon_i;
    end
  end

  // Deep sleep pull-downs only when configured
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      pulldown_en_o <= 1'h0;
    end else begin
      pulldown_en_o <= deep_sleep_state_i && deep_sleep_config_pd_i;
    end
  end
endmodule // srss_top

// [common/srss_defs.vh]
// Function
// - Debounce the active-low reset request; request internal reset only once confirmed.
// - Reset request with SMBus idle applies reset at once, no waiting.
// - With SMBus busy, wait for idle at most 25 ms, then force reset.
// - Active-low regulator alert input means maximum-current throttling indication.
// - Shared clock-run line decides whether both LPC clock outputs run or stop.
// - In LPC mode, assert active-low suspend notice ahead of low-power entry.
// - In eSPI mode the suspend notice pin carries the sideband_bus_reset_n instead.
// - Deep sleep pull-downs on AC-present and wake inputs only when configured.
`ifndef SRSS_DEFS_VH
`define SRSS_DEFS_VH

// Bus-idle wait limit: 25 ms in cycles of the 8 ns clock
`define SRSS_BUSY_WAIT_CYC 24'h2faf08
// Debounce default; the pin has no set duration
`define SRSS_DEBOUNCE_CYC 24'h000010
`define SRSS_CNT_W 24
// Clock-run stop request: cycles of quiet line before clocks stop
`define SRSS_CLOCK_RUN_REQUEST_N_QUIET 4'h8
`define SRSS_CLOCK_RUN_REQUEST_N_W 4
// Pin synchroniser lanes and their idle level
`define SRSS_PIN_W 4
`define SRSS_PIN_IDLE 4'hf
`define SRSS_PIN_RST 3
`define SRSS_PIN_ALERT 2
`define SRSS_PIN_WAKE 1
`define SRSS_PIN_CLOCK_RUN_REQUEST_N 0

`endif

// [hdl/srss_sync.v]
`timescale 1ns/1ps
// Two-flop synchroniser for a bank of pin inputs
module srss_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  // Clock and reset
  input wire clk_i,
  input wire resetn_i,
  // Data
  input wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  // First stage feeds only the second
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      meta_r <= INIT;
      sync_r <= INIT;
    end else begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end

  assign q_o = sync_r;
endmodule // srss_sync

// [test/srss_monitor.sv]
`timescale 1ns/1ps
// Ties each sideband output except the clock-run line drive and the wake data to its cause at the pins
module srss_monitor (
  // Clock and reset
  input wire clk_i, resetn_i,
  // Pins and controls
  input wire system_reset_request_n_i, smbus_busy_i, regulator_alert_n_i,
  input wire sleep_state_i, pcie_wake_n_i, clock_run_request_n_i,
  input wire espi_mode_i, suspend_soon_i, sideband_reset_req_i,
  input wire deep_sleep_state_i, deep_sleep_config_pd_i,
  // Outputs
  input wire internal_reset_req_o, throttle_o, wake_event_o,
  input wire lpc_clock_enable_o, suspend_notice_n_o, pulldown_en_o,
  input wire pcie_wake_n_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // Request held past sync and debounce
  sequence held_low;
    (!system_reset_request_n_i)[*8];
  endsequence
  deb_min_a: assert property ($rose(internal_reset_req_o) |->
    !$past(system_reset_request_n_i, 3) && !$past(system_reset_request_n_i, 6))
    else $error("reset without settled request");
  rst_now_a: assert property (
    (!system_reset_request_n_i && !smbus_busy_i)[*8] |=> internal_reset_req_o)
    else $error("reset late on idle bus");
  // Bound covers the shortened wait plus sync and debounce
  wait_cap_a: assert property (held_low |-> ##[0:56]
    (internal_reset_req_o || system_reset_request_n_i))
    else $error("bus wait not bounded");
  thr_on_a: assert property ((!regulator_alert_n_i)[*4] |-> throttle_o)
    else $error("alert not seen");
  wake_in_a: assert property ((sleep_state_i && !pcie_wake_n_i)[*4] |->
    wake_event_o && !pcie_wake_n_oe_o) else $error("wake not taken");
  clk_run_a: assert property ((!clock_run_request_n_i)[*4] |->
    ##[0:2] lpc_clock_enable_o) else $error("clocks not restarted");
  // Past reset guard keeps reset-time inputs out
  sus_lpc_a: assert property ($past(resetn_i) && !$past(espi_mode_i) |->
    suspend_notice_n_o == !$past(suspend_soon_i)) else $error("notice wrong");
  espi_rst_a: assert property ($past(resetn_i) && $past(espi_mode_i) |->
    suspend_notice_n_o == !$past(sideband_reset_req_i))
    else $error("bus reset wrong");
  pd_cfg_a: assert property ($past(resetn_i) |-> pulldown_en_o ==
    ($past(deep_sleep_state_i) && $past(deep_sleep_config_pd_i)))
    else $error("pull-down wrong");
endmodule // srss_monitor
bind srss_top srss_monitor i_mon (.*);

// [test/srss_periph.sv]
`timescale 1ns/1ps
// Peripheral side of the shared open-drain lines
module srss_periph (
  // Requests from the bench
  input wire need_clock_i, need_wake_i,
  // Device side
  input wire clock_run_request_n_oe_i, wake_oe_i, notice_n_i,
  output wire clock_run_request_n_n_o, wake_n_o, isolate_o
);
  // Pull-ups hold each line high unless someone pulls it low
  assign clock_run_request_n_n_o = !(need_clock_i || clock_run_request_n_oe_i);
  assign wake_n_o = !(need_wake_i || wake_oe_i);
  // Optional output isolation while notice is low
  assign isolate_o = !notice_n_i;
endmodule // srss_periph

// [test/srss_top_tb.sv]
`timescale 1ns/1ps
// Directed checks of the sideband block
module srss_top_tb;
  logic clk_i, resetn_i, system_reset_request_n_i, smbus_busy_i;
  logic regulator_alert_n_i, sleep_state_i, deep_sleep_state_i, espi_mode_i;
  logic suspend_soon_i, sideband_reset_req_i, clock_stop_req_i;
  logic deep_sleep_config_pd_i, pcie_wake_n_i, pcie_wake_n_o, pcie_wake_n_oe_o;
  logic clock_run_request_n_i, clock_run_request_n_o, clock_run_request_n_oe_o;
  logic internal_reset_req_o, throttle_o, wake_event_o, lpc_clock_enable_o;
  logic suspend_notice_n_o, pulldown_en_o, need_clk, need_wake;
  int mismatches, checks, cyc;
  // Short counts keep the bus wait inside a brief run
  srss_top #(.DEBOUNCE_CYC(24'h4), .BUSY_WAIT_CYC(24'h32)) i_dut (.*);
  srss_periph i_per (.need_clock_i(need_clk), .need_wake_i(need_wake),
    .clock_run_request_n_oe_i(clock_run_request_n_oe_o), .wake_oe_i(pcie_wake_n_oe_o),
    .notice_n_i(suspend_notice_n_o), .clock_run_request_n_n_o(clock_run_request_n_i),
    .wake_n_o(pcie_wake_n_i), .isolate_o());
  initial begin
    clk_i = 0;
    forever #4 clk_i = ~clk_i;
  end
  // Hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      stop_test;
    end
  end
  task w(int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task chk(string s, logic e, logic g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s exp %b got %b", s, e, g);
    end
  endtask
  task stop_test;
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Reset request; bus frees after d cycles, rise due in lo..hi
  task t_rst(int d, int lo, int hi);
    int n;
    n = 0;
    smbus_busy_i = d > 0;
    system_reset_request_n_i = 0;
    while (internal_reset_req_o !== 1'b1 && n < 80) begin
      w(1);
      n++;
      if (n == d) smbus_busy_i = 0;
    end
    chk("reset delay", 1, n >= lo && n <= hi);
    system_reset_request_n_i = 1;
    smbus_busy_i = 0;
    w(12);
    chk("reset release", 0, internal_reset_req_o);
  endtask
  // Pulse shorter than the debounce never reaches the reset
  task t_glitch;
    system_reset_request_n_i = 0;
    w(2);
    system_reset_request_n_i = 1;
    repeat (12) begin
      w(1);
      chk("glitch", 0, internal_reset_req_o);
    end
  endtask
  task t_pins;
    regulator_alert_n_i = 0;
    sleep_state_i = 1;
    need_wake = 1;
    w(4);
    chk("throttle", 1, throttle_o);
    chk("wake", 1, wake_event_o);
    chk("wake oe", 0, pcie_wake_n_oe_o);
    chk("wake data", 0, pcie_wake_n_o);
    regulator_alert_n_i = 1;
    need_wake = 0;
    w(4);
    chk("throttle", 0, throttle_o);
    chk("wake", 0, wake_event_o);
  endtask
  // Stop clocks, then a peripheral asks them back
  task t_clock_run_request_n;
    clock_stop_req_i = 1;
    w(14);
    chk("clk stop", 0, lpc_clock_enable_o);
    need_clk = 1;
    w(5);
    chk("clk run", 1, lpc_clock_enable_o);
    need_clk = 0;
    w(14);
    chk("clk stop again", 0, lpc_clock_enable_o);
    clock_stop_req_i = 0;
    w(1);
    chk("clk restart", 1, lpc_clock_enable_o);
    chk("clock_run_request_n drive", 1, clock_run_request_n_oe_o);
    chk("clock_run_request_n data", 0, clock_run_request_n_o);
    w(1);
    chk("clock_run_request_n release", 0, clock_run_request_n_oe_o);
  endtask
  // Opposite levels on the two notice sources expose a mode mix-up
  task t_modes;
    for (int m = 0; m < 4; m++) begin
      espi_mode_i = m[1];
      suspend_soon_i = m[0];
      sideband_reset_req_i = !m[0];
      deep_sleep_state_i = m[1];
      deep_sleep_config_pd_i = m[0];
      w(2);
      chk("notice", m[1] ? m[0] : !m[0], suspend_notice_n_o);
      chk("pull-down", m[0] && m[1], pulldown_en_o);
    end
  endtask
  // Mid-run reset: outputs drop to reset levels, then follow again
  task t_reset;
    resetn_i = 0;
    w(1);
    chk("reset notice", 0, suspend_notice_n_o);
    chk("reset pull-down", 0, pulldown_en_o);
    chk("reset clocks", 1, lpc_clock_enable_o);
    chk("reset request", 0, internal_reset_req_o);
    resetn_i = 1;
    w(3);
    chk("notice after reset", 1, suspend_notice_n_o);
    chk("pull-down after reset", 1, pulldown_en_o);
    chk("no false request", 0, internal_reset_req_o);
  endtask
  initial begin
    {resetn_i, smbus_busy_i, sleep_state_i, deep_sleep_state_i} = 4'h0;
    {espi_mode_i, suspend_soon_i, sideband_reset_req_i} = 3'h0;
    {clock_stop_req_i, deep_sleep_config_pd_i, need_clk, need_wake} = 4'h0;
    {system_reset_request_n_i, regulator_alert_n_i} = 2'h3;
    w(5);
    resetn_i = 1;
    w(3);
    t_rst(0, 7, 7);
    t_rst(15, 15, 18);
    t_rst(99, 52, 62);
    t_glitch;
    t_pins;
    t_clock_run_request_n;
    t_modes;
    t_reset;
    stop_test;
  end
endmodule // srss_top_tb
